// File: pkg/two_wire_pkg.sv
`default_nettype none
package two_wire_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and control field positions
  // ----------------------------------------------------------------------
  localparam logic [1:0] OFS_CONTROL  = 2'h0;
  localparam logic [1:0] OFS_STATUS   = 2'h1;
  localparam logic [1:0] OFS_DATA     = 2'h2;
  localparam logic [1:0] OFS_OWN_ADDR = 2'h3;

  localparam int CTL_FLAG  = 7;
  localparam int CTL_ACK   = 6;
  localparam int CTL_BEGIN = 5;
  localparam int CTL_END   = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IE    = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_OWN_ADDR = 8'h00;
  localparam logic [7:0] RST_DATA     = 8'hFF;
  localparam logic [1:0] RST_PRESC    = 2'h0;

  // ----------------------------------------------------------------------
  // Condition codes, prescaler bits at zero
  // ----------------------------------------------------------------------
  localparam logic [7:0] CODE_OWN_W     = 8'h60;
  localparam logic [7:0] CODE_ARB_OWN_W = 8'h68;
  localparam logic [7:0] CODE_GC        = 8'h70;
  localparam logic [7:0] CODE_ARB_GC    = 8'h78;
  localparam logic [7:0] CODE_OWN_ACK   = 8'h80;
  localparam logic [7:0] CODE_OWN_NACK  = 8'h88;
  localparam logic [7:0] CODE_GC_ACK    = 8'h90;
  localparam logic [7:0] CODE_GC_NACK   = 8'h98;
  localparam logic [7:0] CODE_STOP      = 8'hA0;
  localparam logic [7:0] CODE_NONE      = 8'hF8;

  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum {S_IDLE, S_ADDR, S_DATA, S_ACK, S_HOLD, S_SKIP} state_t;

endpackage : two_wire_pkg
`default_nettype wire

// File: verilog/two_wire_slave_receiver.sv
`default_nettype none
module two_wire_slave_receiver
  import two_wire_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk_in,
  input  wire logic     sys_rst_in,
  // Register port
  input  wire reg_req_t reg_req_in,
  output logic [7:0]    reg_rdata_out,
  // Bus pins, open drain
  input  wire logic     scl_in,
  output logic          scl_out,
  output logic          scl_oe_out,
  input  wire logic     sda_in,
  output logic          sda_out,
  output logic          sda_oe_out,
  // System side
  input  wire logic     sleep_in,
  input  wire logic     master_arb_lost_in,
  output logic          wake_out,
  output logic          start_req_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------------------------------------
  logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      {scl_meta, scl_s, scl_d} <= 3'h7;
      {sda_meta, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_meta, scl_s, scl_d} <= {scl_in, scl_meta, scl_s};
      {sda_meta, sda_s, sda_d} <= {sda_in, sda_meta, sda_s};
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------------
  // Software visible state
  // ----------------------------------------------------------------------
  logic       int_flag, ack_en, begin_req, end_req, wcol, en, ie;
  logic [7:0] own_addr, data_reg, code;
  logic [1:0] presc;
  logic       ctl_wr, data_wr, clr_flag;
  assign ctl_wr   = reg_req_in.wr && reg_req_in.addr == OFS_CONTROL;
  assign data_wr  = reg_req_in.wr && reg_req_in.addr == OFS_DATA;
  assign clr_flag = ctl_wr && reg_req_in.wdata[CTL_FLAG];
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack_en    <= 1'b0;
      begin_req <= 1'b0;
      end_req   <= 1'b0;
      en        <= 1'b0;
      ie        <= 1'b0;
    end else if (ctl_wr) begin
      ack_en    <= reg_req_in.wdata[CTL_ACK];
      begin_req <= reg_req_in.wdata[CTL_BEGIN];
      end_req   <= reg_req_in.wdata[CTL_END];
      en        <= reg_req_in.wdata[CTL_EN];
      ie        <= reg_req_in.wdata[CTL_IE];
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      own_addr <= RST_OWN_ADDR;
      presc    <= RST_PRESC;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == OFS_OWN_ADDR)
        own_addr <= reg_req_in.wdata;
      if (reg_req_in.addr == OFS_STATUS)
        presc <= reg_req_in.wdata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------------
  state_t     state;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic       selected, is_gc, ack_drive, nack_end, addr_phase, busy;
  logic       addr_hit, gc_hit, byte_end, addr_take;
  assign gc_hit   = shreg[7:1] == GEN_CALL_ADDR && own_addr[0];
  assign addr_hit = shreg[7:1] == own_addr[7:1] || gc_hit;
  assign byte_end = scl_fall && bitcnt == BITS_PER_BYTE;
  // Recognition works in sleep too, but only with acknowledge enabled.
  assign addr_take = state == S_ADDR && byte_end && en && ack_en
                     && !int_flag && addr_hit && !shreg[0];
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state      <= S_IDLE;
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      selected   <= 1'b0;
      is_gc      <= 1'b0;
      ack_drive  <= 1'b0;
      nack_end   <= 1'b0;
      addr_phase <= 1'b0;
    end else if (!en || stop_c) begin
      state     <= S_IDLE;
      selected  <= 1'b0;
      ack_drive <= 1'b0;
    end else if (start_c) begin
      state     <= S_ADDR;
      bitcnt    <= 4'h0;
      selected  <= 1'b0;
      ack_drive <= 1'b0;
    end else begin
      if (scl_rise && (state == S_ADDR || state == S_DATA)
          && bitcnt != BITS_PER_BYTE) begin
        shreg  <= {shreg[6:0], sda_s};
        bitcnt <= bitcnt + 4'h1;
      end
      unique case (state)
        S_IDLE, S_SKIP: begin
        end
        S_ADDR: begin
          if (addr_take) begin
            state      <= S_ACK;
            ack_drive  <= 1'b1;
            selected   <= 1'b1;
            is_gc      <= gc_hit && shreg[7:1] != own_addr[7:1];
            nack_end   <= 1'b0;
            addr_phase <= 1'b1;
          end else if (byte_end) begin
            state <= S_SKIP;
          end
        end
        S_DATA: begin
          if (byte_end) begin
            state      <= S_ACK;
            ack_drive  <= ack_en;
            nack_end   <= !ack_en;
            addr_phase <= 1'b0;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            ack_drive <= 1'b0;
            state     <= S_HOLD;
          end
        end
        S_HOLD: begin
          // The line stays low here until software releases the flag.
          if (!int_flag) begin
            bitcnt <= 4'h0;
            if (nack_end) begin
              state    <= S_IDLE;
              selected <= 1'b0;
            end else begin
              state <= S_DATA;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in)
      busy <= 1'b0;
    else if (start_c)
      busy <= 1'b1;
    else if (stop_c)
      busy <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Flag, condition code and wake-up
  // ----------------------------------------------------------------------
  logic       ack_done, stop_evt, set_evt, arb_pend, arb_hit;
  logic [7:0] next_code;
  assign ack_done = state == S_ACK && scl_fall && en && !start_c && !stop_c;
  assign stop_evt = en && selected && (start_c || stop_c);
  assign set_evt  = ack_done || stop_evt;
  always_comb begin
    if (stop_evt)
      next_code = CODE_STOP;
    else if (addr_phase && is_gc)
      next_code = arb_hit ? CODE_ARB_GC : CODE_GC;
    else if (addr_phase)
      next_code = arb_hit ? CODE_ARB_OWN_W : CODE_OWN_W;
    else if (is_gc)
      next_code = nack_end ? CODE_GC_NACK : CODE_GC_ACK;
    else
      next_code = nack_end ? CODE_OWN_NACK : CODE_OWN_ACK;
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      arb_pend <= 1'b0;
      arb_hit  <= 1'b0;
    end else if (master_arb_lost_in) begin
      arb_pend <= 1'b1;
    end else if (addr_take) begin
      arb_hit  <= arb_pend;
      arb_pend <= 1'b0;
    end
  end
  // A new event wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      int_flag <= 1'b0;
      code     <= CODE_NONE;
      wake_out <= 1'b0;
    end else if (set_evt) begin
      int_flag <= 1'b1;
      code     <= next_code;
      wake_out <= wake_out || (ack_done && addr_phase && sleep_in);
    end else if (clr_flag) begin
      int_flag <= 1'b0;
      code     <= CODE_NONE;
      wake_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Data register and write collision
  // ----------------------------------------------------------------------
  // Bus bytes are not captured while asleep, so after wake-up the data
  // register does not hold the address that woke the part.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in)
      data_reg <= RST_DATA;
    else if (data_wr && int_flag)
      data_reg <= reg_req_in.wdata;
    else if (!sleep_in && (addr_take || (state == S_DATA && byte_end)))
      data_reg <= shreg;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in)
      wcol <= 1'b0;
    else if (data_wr)
      wcol <= !int_flag;
  end

  // ----------------------------------------------------------------------
  // Read port and pins
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        OFS_CONTROL:  reg_rdata_out <= {int_flag, ack_en, begin_req,
                                        end_req, wcol, en, 1'b0, ie};
        OFS_STATUS:   reg_rdata_out <= {code[7:3], 1'b0, presc};
        OFS_DATA:     reg_rdata_out <= data_reg;
        OFS_OWN_ADDR: reg_rdata_out <= own_addr;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  assign scl_out       = 1'b0;
  assign sda_out       = 1'b0;
  assign sda_oe_out    = ack_drive;
  assign scl_oe_out    = state == S_HOLD && int_flag;
  assign start_req_out = begin_req && en && !busy && state == S_IDLE;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_addr_ack; addr_take |=> sda_oe_out && state == S_ACK; endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no address ack");
  property p_gc_off;
    state == S_ADDR && byte_end && shreg[7:1] == GEN_CALL_ADDR
      && own_addr[7:1] != GEN_CALL_ADDR && !own_addr[0] |=> !sda_oe_out;
  endproperty
  a_gc_off: assert property (p_gc_off) else $error("gc acked");
  property p_read_dir;
    state == S_ADDR && byte_end && !start_c && !stop_c && shreg[0]
      |=> state == S_SKIP && !sda_oe_out;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read taken");
  property p_nack;
    state == S_DATA && byte_end && en && !start_c && !stop_c && !ack_en
      |=> !sda_oe_out [*2];
  endproperty
  a_nack: assert property (p_nack) else $error("data acked");
  property p_ack_off;
    !ack_en && state == S_ADDR && byte_end |=> !sda_oe_out;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("addr taken");
  property p_stretch; ack_done |=> scl_oe_out; endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");
  property p_wake; wake_out |-> int_flag; endproperty
  a_wake: assert property (p_wake) else $error("wake w/o flag");
  property p_sleep_data;
    sleep_in && !data_wr |=> $stable(data_reg);
  endproperty
  a_sleep_data: assert property (p_sleep_data) else $error("data moved");
  property p_status_rd;
    reg_req_in.rd && reg_req_in.addr == OFS_STATUS
      |=> reg_rdata_out == {$past(code[7:3]), 1'b0, $past(presc)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("bad status");
  property p_stop_code;
    stop_evt |=> int_flag && code == CODE_STOP && state != S_HOLD;
  endproperty
  a_stop_code: assert property (p_stop_code) else $error("no stop code");
  property p_own_code;
    ack_done && addr_phase && !is_gc && !arb_hit
      |=> int_flag && code == CODE_OWN_W;
  endproperty
  a_own_code: assert property (p_own_code) else $error("bad code");
  c_own:  cover property (ack_done && addr_phase ##1 code == CODE_OWN_W);
  c_data: cover property (code == CODE_OWN_ACK ##[1:200] !int_flag);
  c_stop: cover property (stop_evt);
  c_wake: cover property ($rose(wake_out));
endmodule : two_wire_slave_receiver
`default_nettype wire

// File: tb/two_wire_master_model.sv
`default_nettype none
module two_wire_master_model (
  // Wire levels
  input  wire logic scl_line_in,
  input  wire logic sda_line_in,
  // Open-drain pulls, high pulls the wire low
  output logic      scl_low_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------------
  // A slave may stretch the clock, so the high phase starts only once the
  // wire itself is seen high.
  task automatic rise_scl();
    scl_low_out = 1'b0;
    wait (scl_line_in === 1'b1);
    #20;
  endtask : rise_scl

  task automatic start_cond();
    sda_low_out = 1'b0;
    #20;
    rise_scl();
    sda_low_out = 1'b1;
    #20;
    scl_low_out = 1'b1;
    #20;
  endtask : start_cond

  task automatic stop_cond();
    sda_low_out = 1'b1;
    #20;
    rise_scl();
    sda_low_out = 1'b0;
    #40;
  endtask : stop_cond

  // Eight bits go out first, then the line is released for the answer.
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic seen;
    seen = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      sda_low_out = (i > 0) ? !b[i-1] : 1'b0;
      #20;
      rise_scl();
      seen = sda_line_in;
      #20;
      scl_low_out = 1'b1;
      #20;
    end
    acked = !seen;
  endtask : send_byte
endmodule : two_wire_master_model
`default_nettype wire

// File: tb/test_two_wire_slave_receiver.sv
`default_nettype none
module test_two_wire_slave_receiver
  import two_wire_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_req_t    req = '0;
  logic        sleep = 1'b0;
  logic        arb = 1'b0;
  logic [7:0]  rdata;
  logic        scl_oe, scl_o, sda_oe, sda_o, wake, start_req;
  logic        m_scl, m_sda, ack;
  logic        rd_last = 1'b0;
  int          bad_count = 0;
  int          comparisons = 0;
  integer      seed = 32'h08DF0770;
  logic [15:0] exp_q[$];
  logic [6:0]  own;
  logic [7:0]  dat;
  wire logic   scl = !m_scl && !(scl_oe && !scl_o);
  wire logic   sda = !m_sda && !(sda_oe && !sda_o);

  always #2 clk = ~clk;

  two_wire_slave_receiver u_two_wire_slave_receiver (
    .ref_clk_in        (clk),
    .sys_rst_in        (rst),
    .reg_req_in        (req),
    .reg_rdata_out     (rdata),
    .scl_in            (scl),
    .scl_out           (scl_o),
    .scl_oe_out        (scl_oe),
    .sda_in            (sda),
    .sda_out           (sda_o),
    .sda_oe_out        (sda_oe),
    .sleep_in          (sleep),
    .master_arb_lost_in(arb),
    .wake_out          (wake),
    .start_req_out     (start_req)
  );

  two_wire_master_model u_two_wire_master_model (
    .scl_line_in(scl),
    .sda_line_in(sda),
    .scl_low_out(m_scl),
    .sda_low_out(m_sda)
  );

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) begin
    if (rd_last) begin
      chk(rdata & exp_q[0][15:8], exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
    rd_last <= req.rd;
  end

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------
  task automatic reg_op(input logic [1:0] a, input logic [7:0] d,
                        input logic w);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req <= '0;
  endtask : reg_op

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e,
                        input logic [7:0] m);
    exp_q.push_back({m, e & m});
    reg_op(a, 8'h00, 1'b0);
  endtask : rd_chk

  // Prescaler bits are masked off so only the code is compared.
  task automatic stat(input logic [7:0] c);
    rd_chk(OFS_STATUS, c, 8'hF8);
  endtask : stat

  task automatic ctl(input logic [7:0] d);
    reg_op(OFS_CONTROL, d, 1'b1);
  endtask : ctl

  task automatic settle(input logic e_scl, input logic e_wake);
    repeat (3) @(posedge clk);
    chk({6'h00, wake, scl_oe}, {6'h00, e_wake, e_scl});
  endtask : settle

  task automatic send(input logic [7:0] b, input logic e);
    u_two_wire_master_model.send_byte(b, ack);
    chk({7'h00, ack}, {7'h00, e});
  endtask : send

  task automatic addr(input logic [7:0] b, input logic e);
    u_two_wire_master_model.start_cond();
    send(b, e);
  endtask : addr

  task automatic lose();
    @(posedge clk);
    arb <= 1'b1;
    @(posedge clk);
    arb <= 1'b0;
  endtask : lose

  task automatic stop_a0();
    u_two_wire_master_model.stop_cond();
    stat(CODE_STOP);
    settle(1'b0, 1'b0);
    ctl(8'hC4);
  endtask : stop_a0

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    own = 7'($random(seed)) | 7'h01;
    dat = 8'($random(seed));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CONTROL, 8'h00, 8'hFF);
    rd_chk(OFS_DATA, RST_DATA, 8'hFF);
    rd_chk(OFS_OWN_ADDR, RST_OWN_ADDR, 8'hFF);
    reg_op(OFS_STATUS, 8'h03, 1'b1);
    rd_chk(OFS_STATUS, CODE_NONE | 8'h03, 8'hFF);
    reg_op(OFS_OWN_ADDR, {own, 1'b1}, 1'b1);
    rd_chk(OFS_OWN_ADDR, {own, 1'b1}, 8'hFF);
    ctl(8'h44);
    addr({own ^ 7'h02, 1'b0}, 1'b0);
    addr({own, 1'b1}, 1'b0);
    addr({own, 1'b0}, 1'b1);
    stat(CODE_OWN_W);
    rd_chk(OFS_CONTROL, 8'h80, 8'h80);
    settle(1'b1, 1'b0);
    ctl(8'hC4);
    settle(1'b0, 1'b0);
    send(dat, 1'b1);
    stat(CODE_OWN_ACK);
    rd_chk(OFS_DATA, dat, 8'hFF);
    ctl(8'h84);
    send(~dat, 1'b0);
    stat(CODE_OWN_NACK);
    ctl(8'h84);
    addr({own, 1'b0}, 1'b0);
    ctl(8'h44);
    addr(8'h00, 1'b1);
    stat(CODE_GC);
    ctl(8'hC4);
    send(dat, 1'b1);
    stat(CODE_GC_ACK);
    ctl(8'h84);
    send(dat, 1'b0);
    stat(CODE_GC_NACK);
    ctl(8'hC4);
    lose();
    addr({own, 1'b0}, 1'b1);
    stat(CODE_ARB_OWN_W);
    ctl(8'hC4);
    send(dat, 1'b1);
    ctl(8'hC4);
    stop_a0();
    lose();
    addr(8'h00, 1'b1);
    stat(CODE_ARB_GC);
    ctl(8'hC4);
    send(~{own, 1'b0}, 1'b1);
    ctl(8'hC4);
    stop_a0();
    @(posedge clk);
    sleep <= 1'b1;
    addr({own, 1'b0}, 1'b1);
    settle(1'b1, 1'b1);
    @(posedge clk);
    sleep <= 1'b0;
    ctl(8'hC4);
    settle(1'b0, 1'b0);
    rd_chk(OFS_DATA, ~{own, 1'b0}, 8'hFF);
    stop_a0();
    reg_op(OFS_OWN_ADDR, {own, 1'b0}, 1'b1);
    addr(8'h00, 1'b0);
    u_two_wire_master_model.stop_cond();
    ctl(8'h24);
    repeat (3) @(posedge clk);
    chk({7'h00, start_req}, 8'h01);
    give_verdict();
  end
endmodule : test_two_wire_slave_receiver
`default_nettype wire
